// ---- cbf_top.sv ----
// Buffer configuration registers and acceptance filtering for a CAN core.
// Assumes the protocol engine presents a received frame for one cycle.
module cbf_top (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic        i_rx_valid,
    input  wire logic        i_rx_ext,
    input  wire logic        i_rx_rtr,
    input  wire logic [28:0] i_rx_id,
    input  wire logic [3:0]  i_rx_dlc,
    input  wire logic [63:0] i_rx_data,
    output logic             o_accept,
    output logic      [4:0]  o_accept_code,
    output logic      [3:0]  o_accept_ptr,
    output logic      [5:0]  o_buf_tx_dir,
    output logic      [1:0]  o_mode
);
    import cbf_pkg::*;

    typedef struct packed {
        logic [15:0][3:0][7:0] filt;
        logic [1:0][3:0][7:0]  mask;
        logic [15:0]           fen;
        logic [5:0]            dir;
        logic [1:0]            mode;
        logic [15:0][1:0]      msel;
        logic [15:0][3:0]      bptr;
        logic [5:0][7:0][7:0]  data;
        logic [5:0][7:0]       len;
        logic [5:0][4:0]       hitc;
        logic [7:0]            rdata;
        logic                  hit;
        logic [4:0]            code;
        logic [3:0]            ptr;
    } cbf_state_s;

    cbf_state_s st;
    cbf_state_s next_st;

    logic        enh;
    logic        is_filt;
    logic        is_mask;
    logic        is_buf;
    logic [3:0]  a_f;
    logic [1:0]  a_k;
    logic        a_m;
    logic [3:0]  a_bw;
    logic [2:0]  a_b;
    logic [3:0]  a_sub;
    logic [15:0] match;
    logic [15:0] ftype;
    logic        any;
    logic [3:0]  win;
    logic [3:0]  wptr;
    logic [2:0]  bi;
    logic        do_store;
    logic [7:0]  rval;
    logic [7:0]  v;

    assign enh     = st.mode != MODE_LEGACY;
    assign is_filt = i_addr < A_MASK;
    assign is_mask = i_addr[7:3] == A_MASK[7:3];
    assign a_f     = i_addr[5:2];
    assign a_k     = i_addr[1:0];
    assign a_m     = i_addr[2];
    assign a_bw    = 4'(i_addr[7:4] - A_BUF[7:4]);
    assign a_b     = a_bw[2:0];
    assign a_sub   = i_addr[3:0];
    assign is_buf  = (i_addr >= A_BUF) && (a_bw < 4'(NBUF)) && (a_sub <= BUF_HIT);

    // Per-filter mask choice and compare
    genvar g;
    generate
        for (g = 0; g < NFILT; g++) begin : g_filt
            logic [1:0]      sel;
            logic [3:0][7:0] mb;
            logic            en;
            logic            tchk;
            // Legacy has no choice register: filters 0-1 use mask 0, the rest mask 1
            assign sel = enh ? st.msel[g] : ((g < 2) ? MSEL_MASK0 : MSEL_MASK1);
            always_comb begin
                unique case (sel)
                    MSEL_MASK0: mb = st.mask[0];
                    MSEL_MASK1: mb = st.mask[1];
                    MSEL_F15:   mb = st.filt[NFILT-1];
                    MSEL_NONE:  mb = '0;
                endcase
            end
            assign en    = enh ? st.fen[g] : (g < LEGACY_FILTS);
            // Legacy always enforces the filter type; the mask cannot relax it
            assign tchk  = enh ? mb[1][TYPE_BIT] : 1'b1;
            assign ftype[g] = st.filt[g][1][TYPE_BIT];
            cbf_match u_match (
                .i_en        (en),
                .i_frame_id  (i_rx_id),
                .i_frame_ext (i_rx_ext),
                .i_filt_id   (id_of(st.filt[g])),
                .i_filt_ext  (ftype[g]),
                .i_mask_id   (id_of(mb)),
                .i_type_chk  (tchk),
                .o_hit       (match[g])
            );
        end
    endgenerate

    // Lowest-numbered hit wins
    always_comb begin
        win = 4'h0;
        for (int i = NFILT - 1; i >= 0; i--) begin
            if (match[i]) begin
                win = 4'(i);
            end
        end
    end

    assign any  = i_rx_valid && (|match);
    assign wptr = enh ? st.bptr[win] : ((win < 4'h2) ? PTR_RX0 : PTR_RX1);
    assign bi   = 3'(wptr - PTR_BUF0);
    // Reserved pointers and transmit-mode buffers take no data
    assign do_store = any && enh && (wptr >= PTR_BUF0) && (wptr <= PTR_BUFN)
                      && !st.dir[bi];

    always_comb begin
        next_st = st;
        next_st.hit = 1'b0;
        rval = RST_BYTE;
        v = RST_BYTE;
        // Reads
        if (is_filt && (enh || a_f < 4'(LEGACY_FILTS))) begin
            rval = st.filt[a_f][a_k];
        end
        if (is_mask) begin
            rval = st.mask[a_m][a_k];
            if (!enh && a_k == 2'd1) begin
                rval[TYPE_BIT] = 1'b0;
            end
        end
        if (enh) begin
            unique case (i_addr)
                A_FEN_LO: rval = st.fen[7:0];
                A_FEN_HI: rval = st.fen[15:8];
                A_DIR:    rval = {st.dir, 2'b00};
                default: ;
            endcase
            if (i_addr[7:2] == A_MSEL[7:2]) begin
                rval = st.msel[{a_k, 2'b00} +: 4];
            end
            if (i_addr[7:3] == A_BPTR[7:3]) begin
                rval = st.bptr[{i_addr[2:0], 1'b0} +: 2];
            end
            if (is_buf) begin
                if (a_sub < BUF_LEN) begin
                    rval = st.data[a_b][a_sub[2:0]];
                end else if (a_sub == BUF_LEN) begin
                    rval = st.len[a_b] & LEN_IMPL;
                end else begin
                    rval = {3'b000, st.hitc[a_b]};
                end
            end
        end
        if (i_addr == A_MODE) begin
            rval = {6'h00, st.mode};
        end
        if (i_rd) begin
            next_st.rdata = rval;
        end
        // Writes
        if (i_wr) begin
            if (is_filt && (enh || a_f < 4'(LEGACY_FILTS))) begin
                v = (a_k == 2'd1) ? (i_wdata & ID_LOW_IMPL) : i_wdata;
                next_st.filt[a_f][a_k] = v;
            end
            if (is_mask) begin
                v = (a_k == 2'd1) ? (i_wdata & ID_LOW_IMPL) : i_wdata;
                if (!enh && a_k == 2'd1) begin
                    v[TYPE_BIT] = st.mask[a_m][1][TYPE_BIT];
                end
                next_st.mask[a_m][a_k] = v;
            end
            if (i_addr == A_MODE) begin
                next_st.mode = i_wdata[1:0] & MODE_IMPL;
            end
            if (enh) begin
                unique case (i_addr)
                    A_FEN_LO: next_st.fen[7:0]  = i_wdata;
                    A_FEN_HI: next_st.fen[15:8] = i_wdata;
                    A_DIR:    next_st.dir = i_wdata[7:2];
                    default: ;
                endcase
                if (i_addr[7:2] == A_MSEL[7:2]) begin
                    next_st.msel[{a_k, 2'b00} +: 4] = i_wdata;
                end
                if (i_addr[7:3] == A_BPTR[7:3]) begin
                    next_st.bptr[{i_addr[2:0], 1'b0} +: 2] = i_wdata;
                end
                // Receive-mode buffers ignore software writes
                if (is_buf && st.dir[a_b]) begin
                    if (a_sub < BUF_LEN) begin
                        next_st.data[a_b][a_sub[2:0]] = i_wdata;
                    end else if (a_sub == BUF_LEN) begin
                        next_st.len[a_b] = i_wdata & LEN_IMPL;
                    end
                end
            end
        end
        // Reception; a write to the same buffer is already ignored
        if (any) begin
            next_st.hit  = 1'b1;
            next_st.code = {1'b0, win};
            next_st.ptr  = wptr;
        end
        if (do_store) begin
            // All eight bytes are copied; reserved lengths above eight are
            // stored as received and left to software to reject
            next_st.data[bi] = i_rx_data;
            next_st.len[bi]  = {1'b0, i_rx_rtr, 2'b00, i_rx_dlc};
            next_st.hitc[bi] = {1'b0, win};
        end
    end

    // Payload bytes reset to zero rather than left undefined
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata       = st.rdata;
    assign o_accept      = st.hit;
    assign o_accept_code = st.code;
    assign o_accept_ptr  = st.ptr;
    assign o_buf_tx_dir  = st.dir;
    assign o_mode        = st.mode;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence store_s;
        do_store;
    endsequence
    sequence len_rd_s;
        i_rd && is_buf && a_sub == BUF_LEN;
    endsequence

    len_rsvd_zero_a: assert property (len_rd_s |=> (o_rdata & ~LEN_IMPL) == 8'h00)
        else $error("length register reserved bits not zero");
    rx_data_ro_a: assert property (i_wr && is_buf && enh && !st.dir[a_b]
                                   && !do_store |=> $stable(st.data))
        else $error("receive buffer changed by a write");
    dir_low_zero_a: assert property (i_rd && i_addr == A_DIR |=> o_rdata[1:0] == 2'b00)
        else $error("direction low bits not zero");
    legacy_absent_a: assert property (i_rd && is_buf && !enh |=> o_rdata == 8'h00)
        else $error("buffer visible in legacy mode");
    filt_low_zero_a: assert property (i_rd && is_filt && a_k == 2'd1
                                      |=> !o_rdata[4] && !o_rdata[2])
        else $error("filter low byte unimplemented bits set");
    legacy_type_a: assert property (any && !enh |-> ftype[win] == i_rx_ext)
        else $error("legacy accept of wrong frame type");
    upper_absent_a: assert property (i_rx_valid && !enh ##1 o_accept
                                     |-> o_accept_code < 5'(LEGACY_FILTS))
        else $error("legacy accept by filter above five");
    mask_type_zero_a: assert property (i_rd && is_mask && a_k == 2'd1 && !enh
                                       |=> !o_rdata[TYPE_BIT])
        else $error("mask type bit visible in legacy mode");
    enable_gate_a: assert property (i_rx_valid && enh && ((match & st.fen) == 16'h0)
                                    |=> !o_accept)
        else $error("accept without an enabled filter");
    hit_code_a: assert property (store_s |=> o_accept
                                 && st.hitc[$past(bi)] == o_accept_code)
        else $error("accepting filter code not recorded");

    // Frames that must leave every buffer untouched: legacy mode, a pointer
    // outside the programmable range, or a target buffer set to transmit
    sequence no_store_s;
        any && !i_wr
        && (!enh || wptr < PTR_BUF0 || wptr > PTR_BUFN || o_buf_tx_dir[bi]);
    endsequence
    // Software writes while the controller sits in legacy mode
    sequence legacy_wr_s;
        i_wr && !enh && i_addr != A_MODE;
    endsequence

    accept_follow_a: assert property (any |=> o_accept)
        else $error("matching frame not accepted");
    accept_quiet_a: assert property (!i_rx_valid |=> !o_accept)
        else $error("accept without a received frame");
    no_store_a: assert property (no_store_s |=> $stable(st.data)
                                 && $stable(st.len) && $stable(st.hitc))
        else $error("buffer written by a frame it may not take");
    dir_write_a: assert property (i_wr && enh && i_addr == A_DIR
                                  |=> o_buf_tx_dir == $past(i_wdata[7:2]))
        else $error("direction write did not land");
    legacy_frozen_a: assert property (legacy_wr_s
                                      |=> $stable({st.fen, st.dir, st.msel, st.bptr, st.data}))
        else $error("enhanced register changed in legacy mode");
    legacy_mask_type_a: assert property (legacy_wr_s
                                         |=> $stable({st.mask[1][1][TYPE_BIT], st.mask[0][1][TYPE_BIT]}))
        else $error("mask type bit written in legacy mode");
    upper_hidden_a: assert property (i_wr && !enh && is_filt
                                     && a_f >= 4'(LEGACY_FILTS) |=> $stable(st.filt))
        else $error("absent filter written in legacy mode");
    len_code_a: assert property (store_s |=> st.len[$past(bi)]
                                 == {1'b0, $past(i_rx_rtr), 2'b00, $past(i_rx_dlc)})
        else $error("received length not recorded");
    legacy_ptr_a: assert property (i_rx_valid && !enh ##1 o_accept
                                   |-> o_accept_ptr <= PTR_RX1)
        else $error("legacy accept outside dedicated buffers");
    fen_write_a: assert property (i_wr && enh && i_addr == A_FEN_HI
                                  |=> st.fen[15:8] == $past(i_wdata))
        else $error("upper enable write did not land");
    tx_write_a: assert property (i_wr && is_buf && enh && o_buf_tx_dir[a_b] && a_sub < BUF_LEN
                                 |=> st.data[$past(a_b)][$past(a_sub[2:0])] == $past(i_wdata))
        else $error("transmit payload write did not land");
    filt_write_a: assert property (i_wr && is_filt && a_k == 2'd0
                                   && (enh || a_f < 4'(LEGACY_FILTS))
                                   |=> st.filt[$past(a_f)][0] == $past(i_wdata))
        else $error("filter high byte write did not land");
    mode_write_a: assert property (i_wr && i_addr == A_MODE
                                   |=> o_mode == $past(i_wdata[1:0]))
        else $error("mode write did not land");
endmodule : cbf_top

// ---- cbf_pkg.sv ----
// Constants shared by the buffer configuration and acceptance filter block.
// Assumes an 8-bit register port and a 29-bit identifier from the engine.
package cbf_pkg;
    localparam int NBUF         = 6;
    localparam int NFILT        = 16;
    localparam int NMASK        = 2;
    localparam int LEGACY_FILTS = 6;
    localparam int TYPE_BIT     = 3;
    localparam int RTR_BIT      = 6;

    // Register map: filter f byte k at A_FILT + 4f + k, mask m byte k at
    // A_MASK + 4m + k, buffer b item s at A_BUF + 16b + s.
    localparam logic [7:0] A_FILT   = 8'h00;
    localparam logic [7:0] A_MASK   = 8'h40;
    localparam logic [7:0] A_FEN_LO = 8'h48;
    localparam logic [7:0] A_FEN_HI = 8'h49;
    localparam logic [7:0] A_DIR    = 8'h4a;
    localparam logic [7:0] A_MODE   = 8'h4b;
    localparam logic [7:0] A_MSEL   = 8'h4c;
    localparam logic [7:0] A_BPTR   = 8'h50;
    localparam logic [7:0] A_BUF    = 8'h60;
    localparam logic [3:0] BUF_LEN  = 4'h8;
    localparam logic [3:0] BUF_HIT  = 4'h9;

    // Implemented bits; the rest read zero
    localparam logic [7:0] ID_LOW_IMPL = 8'heb;
    localparam logic [7:0] LEN_IMPL    = 8'h4f;
    localparam logic [7:0] DIR_IMPL    = 8'hfc;
    localparam logic [1:0] MODE_IMPL   = 2'h3;

    localparam logic [1:0] MODE_LEGACY = 2'h0;
    localparam logic [1:0] MODE_ENH    = 2'h1;
    localparam logic [1:0] MODE_FIFO   = 2'h2;

    localparam logic [1:0] MSEL_MASK0 = 2'h0;
    localparam logic [1:0] MSEL_MASK1 = 2'h1;
    localparam logic [1:0] MSEL_F15   = 2'h2;
    localparam logic [1:0] MSEL_NONE  = 2'h3;

    localparam logic [3:0] PTR_BUF0 = 4'h2;
    localparam logic [3:0] PTR_BUFN = 4'h7;
    localparam logic [3:0] PTR_RX0  = 4'h0;
    localparam logic [3:0] PTR_RX1  = 4'h1;
    localparam logic [3:0] DLC_MAX  = 4'h8;

    // Every register, mode included, clears to zero
    localparam logic [7:0] RST_BYTE = 8'h00;

    function automatic logic [28:0] id_of(input logic [3:0][7:0] b);
        return {b[0], b[1][7:5], b[1][1:0], b[2], b[3]};
    endfunction : id_of
endpackage : cbf_pkg

// ---- cbf_match.sv ----
// One acceptance comparator: a frame identifier against one filter.
// Assumes the caller has already chosen the mask and frame-type check.
module cbf_match (
    input  wire logic        i_en,
    input  wire logic [28:0] i_frame_id,
    input  wire logic        i_frame_ext,
    input  wire logic [28:0] i_filt_id,
    input  wire logic        i_filt_ext,
    input  wire logic [28:0] i_mask_id,
    input  wire logic        i_type_chk,
    output logic             o_hit
);
    logic [28:0] cmp;
    logic        id_ok;
    logic        type_ok;

    // Standard frames carry only the top eleven bits
    assign cmp     = i_frame_ext ? i_mask_id : {i_mask_id[28:18], 18'h0};
    assign id_ok   = ((i_frame_id ^ i_filt_id) & cmp) == 29'h0;
    assign type_ok = !i_type_chk || (i_frame_ext == i_filt_ext);
    assign o_hit   = i_en && id_ok && type_ok;
endmodule : cbf_match

// ---- cbf_engine_model.sv ----
// Behavioural protocol engine that hands received frames to the filter block.
// Assumes the bench asks for one frame with a one-cycle pulse on i_go.
module cbf_engine_model (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic        i_ext,
    input  wire logic        i_rtr,
    input  wire logic [28:0] i_id,
    input  wire logic [3:0]  i_dlc,
    input  wire logic [63:0] i_data,
    output logic             o_valid,
    output logic             o_ext,
    output logic             o_rtr,
    output logic      [28:0] o_id,
    output logic      [3:0]  o_dlc,
    output logic      [63:0] o_data
);
    initial begin
        o_valid = 1'b0;
        o_ext   = 1'b0;
        o_rtr   = 1'b0;
        o_id    = '0;
        o_dlc   = '0;
        o_data  = '0;
    end

    // Outside a frame the fields toggle, so a stale value never looks live
    always @(posedge i_clk) begin
        o_valid <= i_go;
        if (i_go) begin
            o_ext  <= i_ext;
            o_rtr  <= i_rtr;
            o_id   <= i_id;
            o_dlc  <= i_dlc;
            o_data <= i_data;
        end else begin
            o_ext  <= ~o_ext;
            o_rtr  <= ~o_rtr;
            o_id   <= ~o_id;
            o_dlc  <= ~o_dlc;
            o_data <= ~o_data;
        end
    end
endmodule : cbf_engine_model

// ---- cbf_top_tb.sv ----
// Self-checking bench for the buffer configuration and acceptance filter.
// Assumes the register map and one-cycle answer timing of the block's port.
module cbf_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cbf_pkg::*;

    logic        i_clk, i_resetn, i_wr, i_rd, go, g_ext, g_rtr, x, exp;
    logic        rx_valid, rx_ext, rx_rtr, o_accept;
    logic [7:0]  i_addr, i_wdata, o_rdata;
    logic [28:0] g_id, rx_id, id;
    logic [3:0]  g_dlc, rx_dlc, o_accept_ptr;
    logic [63:0] g_data, rx_data;
    logic [4:0]  o_accept_code;
    logic [5:0]  o_buf_tx_dir;
    logic [1:0]  o_mode, s;
    logic [31:0] fw;
    logic [31:0] mw [4];
    logic [15:0] en;
    int          k, m, n_errors, total_checks;

    cbf_engine_model u_cbf_engine_model (.i_clk(i_clk), .i_go(go), .i_ext(g_ext),
        .i_rtr(g_rtr), .i_id(g_id), .i_dlc(g_dlc), .i_data(g_data), .o_valid(rx_valid),
        .o_ext(rx_ext), .o_rtr(rx_rtr), .o_id(rx_id), .o_dlc(rx_dlc), .o_data(rx_data));

    cbf_top u_cbf_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_valid(rx_valid), .i_rx_ext(rx_ext), .i_rx_rtr(rx_rtr), .i_rx_id(rx_id),
        .i_rx_dlc(rx_dlc), .i_rx_data(rx_data), .o_accept(o_accept),
        .o_accept_code(o_accept_code), .o_accept_ptr(o_accept_ptr),
        .o_buf_tx_dir(o_buf_tx_dir), .o_mode(o_mode));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        total_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask : rd

    task automatic wr4(input logic [7:0] a, input logic [31:0] w);
        for (int i = 0; i < 4; i++)
            wr(a + 8'(i), w[31-8*i -: 8]);
    endtask : wr4

    task automatic send(input logic xe, input logic [28:0] fid);
        @(posedge i_clk);
        go     <= 1'b1;
        g_ext  <= xe;
        g_id   <= fid;
        g_rtr  <= 1'($urandom);
        g_dlc  <= 4'($urandom % 9);
        g_data <= {$urandom, $urandom};
        @(posedge i_clk);
        go <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask : send

    function automatic logic [28:0] idw(input logic [31:0] w);
        return {w[31:21], w[17:0]};
    endfunction : idw

    function automatic logic hit(input logic [31:0] f, input logic [31:0] mk_w,
                                 input logic [1:0] sel, input logic [28:0] fid,
                                 input logic xe);
        logic [28:0] mk;
        logic        mt;
        mk = (sel == 2'h3) ? '0 : idw(mk_w);
        mt = (sel != 2'h3) && mk_w[19];
        if (!xe)
            mk = mk & 29'h1ffc0000;
        return (((fid ^ idw(f)) & mk) == '0) && (!mt || (xe == f[19]));
    endfunction : hit

    // A hang is cut short here and counted as a mismatch
    initial begin
        repeat (100000) @(posedge i_clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        {i_resetn, i_addr, i_wdata, i_wr, i_rd, go, g_ext, g_rtr} = '0;
        {g_id, g_dlc, g_data, n_errors, total_checks} = '0;
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        void'($urandom(31259));
        rd(A_DIR, 8'h00);
        rd(A_FEN_HI, 8'h00);
        wr(A_DIR, 8'hff);
        rd(A_DIR, 8'h00);
        wr(A_FEN_LO, 8'hff);
        rd(A_FEN_LO, 8'h00);
        wr(A_FILT + 8'd25, 8'hff);
        rd(A_FILT + 8'd25, 8'h00);
        wr(A_MASK + 8'd1, 8'hff);
        rd(A_MASK + 8'd1, 8'he3);
        wr(A_BUF, 8'h5a);
        rd(A_BUF, 8'h00);
        rd(8'hff, 8'h00);
        // Legacy: filter 4 takes extended frames; mask 1 is clear, yet types stay enforced
        wr4(A_FILT + 8'd16, 32'h5ae934c1);
        send(1'b1, 29'($urandom));
        chk({o_accept, o_accept_code, o_accept_ptr}, {1'b1, 5'd4, PTR_RX1});
        send(1'b0, 29'($urandom) | 29'h00040000);
        chk({o_accept, o_accept_code, o_accept_ptr}, {1'b1, 5'd2, PTR_RX1});
        wr(A_MODE, 8'h01);
        #1;
        chk(o_mode, 2'h1);
        wr(A_DIR, 8'hff);
        rd(A_DIR, 8'hfc);
        chk(o_buf_tx_dir, 6'h3f);
        wr(A_DIR, 8'h08);
        wr(A_BUF + 8'h13, 8'ha5);
        rd(A_BUF + 8'h13, 8'ha5);
        wr(A_BUF + 8'h18, 8'hff);
        rd(A_BUF + 8'h18, 8'h4f);
        rd(A_BUF + BUF_LEN, 8'h00);
        wr(A_BUF, 8'h77);
        rd(A_BUF, 8'h00);
        // Random filters; the first four passes walk every mask choice
        for (int n = 0; n < 40; n++) begin
            k = $urandom % 15;
            s = (n < 4) ? 2'(n) : 2'($urandom);
            fw = $urandom;
            mw[0] = $urandom;
            mw[1] = $urandom;
            mw[2] = $urandom;
            mw[3] = '0;
            wr(A_MODE, 8'(1 + $urandom % 3));
            wr4(A_FILT + 8'(4 * k), fw);
            wr4(A_MASK, mw[0]);
            wr4(A_MASK + 8'd4, mw[1]);
            wr4(A_FILT + 8'd60, mw[2]);
            wr(A_MSEL + 8'(k / 4), 8'(s) << (2 * (k % 4)));
            wr(A_BPTR + 8'(k / 2), 8'h22);
            en = 16'h1 << k;
            wr(A_FEN_LO, en[7:0]);
            wr(A_FEN_HI, en[15:8]);
            rd(A_FILT + 8'(4 * k), fw[31:24]);
            rd(A_FILT + 8'(4 * k + 1), fw[23:16] & 8'heb);
            rd(A_MASK + 8'd1, mw[0][23:16] & 8'heb);
            x = ($urandom % 4 == 0) ? ~fw[19] : fw[19];
            id = idw(fw) ^ (29'($urandom) & ~idw(mw[s]));
            if ($urandom % 4 == 0)
                id = id ^ (29'h1 << ($urandom % 29));
            exp = hit(fw, mw[s], s, id, x);
            send(x, id);
            chk(o_accept, exp);
            if (exp) begin
                chk({o_accept_code, o_accept_ptr}, {5'(k), 4'h2});
                m = $urandom % 8;
                rd(A_BUF + 8'(m), g_data[8*m +: 8]);
                rd(A_BUF + BUF_LEN, {1'b0, g_rtr, 2'b00, g_dlc});
                rd(A_BUF + BUF_HIT, 8'(k));
            end
        end
        // A transmit-mode target and a reserved pointer both leave buffer 1 alone
        wr(A_FEN_HI, 8'h00);
        wr(A_FEN_LO, 8'h01);
        wr(A_MSEL, 8'h03);
        for (int p = 0; p < 2; p++) begin
            en = (p == 0) ? 16'h0003 : 16'h000f;
            wr(A_BPTR, en[7:0]);
            send(1'($urandom), 29'($urandom));
            chk({o_accept, o_accept_code, o_accept_ptr}, {1'b1, 5'd0, en[3:0]});
            rd(A_BUF + 8'h13, 8'ha5);
        end
        tally_and_finish();
    end
endmodule : cbf_top_tb
